// File: core/fsp_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          frequency step and vector surge protection element.
// Assumes: 200 MHz clock; byte addresses on the register bus.
// Notes:   Definitions only.
// Notes on behaviour
// - Frequency evaluation is inhibited while all three line voltages are below the minimum.
// - In step mode each phase is checked against the pickup threshold and the step threshold.
// - A pickup without blocking raises the alarm at once and starts the supervision interval.
// - Inside the interval a trip follows when pickup still holds and the step is reached.
// - An interval that expires without the step locks the element until a new pickup crossing.
// - In surge mode every rising zero crossing of a phase starts a new cycle duration measurement.
// - Each cycle duration is compared with a reference and the angle follows from the deviation.
// - The surge angle must exceed its threshold in the set number of phases, one, two or three.
// - A surge without blocking raises alarm and trip together with no delay.
// - Surge tripping is suppressed while any phase is reported lost.
// - The low voltage lockout acts before any surge decision can be made.
// - A mains failure is detected by the surge function within 60 ms.
// - Slow frequency drift never produces a surge trip.
// - An overfrequency pickup releases only at 99.95 % of the trip value and 0.05 % of nominal.
// - An underfrequency pickup releases only at 100.05 % of the trip value and 0.05 % of nominal.
// - The step is an absolute difference, a fall for under and a rise for over, over an interval.
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define FSP_CLK_PERIOD_PS 5000
`define FSP_US_PS 1000000
`define FSP_US_CYC (`FSP_US_PS / `FSP_CLK_PERIOD_PS)
`define FSP_MS_US 1000
`define FSP_REG_CTRL 6'h00
`define FSP_REG_PICKUP 6'h04
`define FSP_REG_STEP 6'h08
`define FSP_REG_INTERVAL 6'h0c
`define FSP_REG_UV 6'h10
`define FSP_REG_SURGE 6'h14
`define FSP_REG_NOMINAL 6'h18
`define FSP_REG_STATE 6'h1c
`define FSP_REG_IRQ_STAT 6'h20
`define FSP_REG_IRQ_MASK 6'h24
`define FSP_CTRL_MODE_LSB 0
`define FSP_CTRL_NEED_LSB 2
`define FSP_CTRL_BLOCK_BIT 4
`define FSP_RST_CTRL 5'h04
`define FSP_RST_PICKUP 16'hc350
`define FSP_RST_STEP 16'h0320
`define FSP_RST_INTERVAL 16'h0064
`define FSP_RST_UV 16'h0100
`define FSP_RST_SURGE 8'h0a
`define FSP_RST_NOMINAL 16'hc350
`define FSP_RATIO_BASE 32'd10000
`define FSP_RATIO_UP 32'd10005
`define FSP_RATIO_DN 32'd9995
`define FSP_HYST_NOM 32'd5
`define FSP_FULL_TURN 25'd360
`endif

// File: core/fsp_pkg.sv
// Purpose: Types shared by the protection element files.
// Assumes: Frequencies in mHz, magnitudes in raw converter units.
// Notes:   Constants live in fsp_params.svh.
package fsp_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_UNDER_STEP, MODE_OVER_STEP, MODE_SURGE} fsp_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIP, ST_LOCK} fsp_state_e;
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] mag;
  } fsp_phase_s;
  typedef struct packed {
    logic sw_block;
    logic [1:0] need;
    fsp_mode_e mode;
  } fsp_ctrl_s;
endpackage

// File: core/fsp_step_det.sv
// Purpose: Per-phase frequency pickup with dropout band and step check.
// Assumes: freq, thresholds and nominal in mHz.
// Notes:   Release needs both the ratio band and the absolute band.
`include "fsp_params.svh"
module fsp_step_det
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic eval_en,
  input wire logic over,
  input wire logic capture,
  input wire logic [15:0] freq,
  input wire logic [15:0] pickup,
  input wire logic [15:0] nominal,
  input wire logic [15:0] step,
  output logic picked,
  output logic step_hit
);
  logic [15:0] f0;
  logic [31:0] f_s;
  logic [31:0] thr_s;
  logic [31:0] band;
  logic rel_under;
  logic rel_over;
  logic next_picked;
  logic [16:0] rise;
  logic [16:0] fall;
  assign f_s = 32'(freq) * `FSP_RATIO_BASE;
  assign thr_s = 32'(pickup) * `FSP_RATIO_BASE;
  assign band = 32'(nominal) * `FSP_HYST_NOM;
  assign rel_under = f_s >= 32'(pickup) * `FSP_RATIO_UP && f_s >= thr_s + band;
  assign rel_over = f_s <= 32'(pickup) * `FSP_RATIO_DN && f_s + band <= thr_s;
  assign next_picked = !eval_en ? 1'b0 :
                       !picked ? (over ? freq > pickup : freq < pickup) :
                       !(over ? rel_over : rel_under);
  assign rise = {1'b0, freq} - {1'b0, f0};
  assign fall = {1'b0, f0} - {1'b0, freq};
  // Sign bit of the difference rules out the wrong direction
  assign step_hit = over ? (!rise[16] && rise[15:0] >= step) :
                           (!fall[16] && fall[15:0] >= step);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      picked <= 1'b0;
      f0 <= 16'h0000;
    end
    else
    begin
      picked <= next_picked;
      if (capture)
        f0 <= freq;
    end
  end
endmodule // fsp_step_det

// File: core/fsp_surge_det.sv
// Purpose: Per-phase cycle duration measurement and vector surge angle check.
// Assumes: us_tick is a one-cycle pulse every microsecond.
// Notes:   Angle test is dev*360 > deg*ref, so no divider is needed.
`include "fsp_params.svh"
module fsp_surge_det
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic us_tick,
  input wire logic zc,
  input wire logic eval_en,
  input wire logic [7:0] thr_deg,
  output logic exceed
);
  logic [15:0] cnt;
  logic [15:0] ref_t;
  logic ref_ok;
  logic armed;
  logic [15:0] dev;
  logic over_thr;
  assign dev = (cnt >= ref_t) ? cnt - ref_t : ref_t - cnt;
  // Consecutive cycles only: slow drift gives tiny deviations
  assign over_thr = 25'(dev) * `FSP_FULL_TURN > 25'(thr_deg) * 25'(ref_t);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 16'h0000;
      ref_t <= 16'h0000;
      ref_ok <= 1'b0;
      armed <= 1'b0;
      exceed <= 1'b0;
    end
    else if (!eval_en)
    begin
      cnt <= 16'h0000;
      ref_ok <= 1'b0;
      armed <= 1'b0;
      exceed <= 1'b0;
    end
    else if (zc)
    begin
      cnt <= 16'h0000;
      ref_t <= cnt;
      armed <= 1'b1;
      // Count up to the first crossing is a partial cycle, never a reference
      ref_ok <= armed;
      exceed <= ref_ok && over_thr;
    end
    else if (us_tick && cnt != 16'hffff)
      cnt <= cnt + 16'h0001;
  end
endmodule // fsp_surge_det

// File: core/fsp_top.sv
// Purpose: Frequency step and vector surge protection element with an
//          Avalon-MM register slave and a level interrupt.
// Assumes: meas, block_in and phase_lost come from logic on clk; zero_cross
//          comes from pin comparators and is synchronised here.
// Notes:   Alarm and trip are registered, one clock after their cause.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`include "fsp_params.svh"
module fsp_top
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input fsp_phase_s meas_a_b,
  input fsp_phase_s meas_b_c,
  input fsp_phase_s meas_c_a,
  input wire logic [2:0] zero_cross,
  input wire logic block_in,
  input wire logic [2:0] phase_lost,
  output logic alarm,
  output logic trip,
  output logic irq
);
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] off);
    reg_hit = addr == off;
  endfunction

  fsp_ctrl_s ctrl;
  logic [15:0] pickup;
  logic [15:0] step;
  logic [15:0] interval;
  logic [15:0] uv_thr;
  logic [7:0] surge_deg;
  logic [15:0] nominal;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic ack;
  logic done;
  logic wr_done;
  logic rd_clear;
  logic [31:0] rd_mux;

  fsp_phase_s ph [3];
  assign ph[0] = meas_a_b;
  assign ph[1] = meas_b_c;
  assign ph[2] = meas_c_a;

  // Zero crossing pins: three stages, a change counts when stages 2 and 3 agree
  logic [2:0] zc_s1;
  logic [2:0] zc_s2;
  logic [2:0] zc_s3;
  logic [2:0] zc_lvl;
  logic [2:0] zc_edge;

  // Time base
  logic [7:0] us_cnt;
  logic [9:0] ms_cnt;
  logic us_tick;
  logic ms_tick;

  // Evaluation gating
  logic [2:0] mag_low;
  logic all_low;
  logic blocked;
  logic step_mode;
  logic over_mode;
  logic surge_mode;
  logic eval_en;
  logic step_en;
  logic surge_en;

  // Step supervision
  fsp_state_e state;
  fsp_state_e next_state;
  logic [15:0] timer;
  logic [2:0] picked;
  logic [2:0] step_hit;
  logic pick_any;
  logic hit_any;
  logic start_run;
  logic timer_out;

  // Surge
  logic [2:0] exceed;
  logic [1:0] exceed_cnt;
  logic [1:0] need;
  logic surge_cond;

  logic next_alarm;
  logic next_trip;
  logic [3:0] events;
  logic surge_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_phase
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          zc_s1[g] <= 1'b0;
          zc_s2[g] <= 1'b0;
          zc_s3[g] <= 1'b0;
          zc_lvl[g] <= 1'b0;
        end
        else
        begin
          zc_s1[g] <= zero_cross[g];
          zc_s2[g] <= zc_s1[g];
          zc_s3[g] <= zc_s2[g];
          if (zc_s2[g] == zc_s3[g])
            zc_lvl[g] <= zc_s3[g];
        end
      end

      assign zc_edge[g] = zc_s2[g] && zc_s3[g] && !zc_lvl[g];
      assign mag_low[g] = ph[g].mag < uv_thr;

      fsp_step_det u_step (
        .clk(clk),
        .rst_b(rst_b),
        .eval_en(step_en),
        .over(over_mode),
        .capture(start_run),
        .freq(ph[g].freq),
        .pickup(pickup),
        .nominal(nominal),
        .step(step),
        .picked(picked[g]),
        .step_hit(step_hit[g])
      );

      fsp_surge_det u_surge (
        .clk(clk),
        .rst_b(rst_b),
        .us_tick(us_tick),
        .zc(zc_edge[g]),
        .eval_en(surge_en),
        .thr_deg(surge_deg),
        .exceed(exceed[g])
      );
    end
  endgenerate

  // Dividers: microsecond and millisecond enables
  assign us_tick = us_cnt == 8'(`FSP_US_CYC - 1);
  assign ms_tick = us_tick && ms_cnt == 10'(`FSP_MS_US - 1);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      us_cnt <= 8'h00;
      ms_cnt <= 10'h000;
    end
    else
    begin
      us_cnt <= us_tick ? 8'h00 : us_cnt + 8'h01;
      if (us_tick)
        ms_cnt <= ms_tick ? 10'h000 : ms_cnt + 10'h001;
    end
  end

  // Lockout is combinational on the live magnitudes, ahead of any decision
  assign all_low = &mag_low;
  assign blocked = ctrl.sw_block || block_in;
  assign step_mode = ctrl.mode == MODE_UNDER_STEP || ctrl.mode == MODE_OVER_STEP;
  assign over_mode = ctrl.mode == MODE_OVER_STEP;
  assign surge_mode = ctrl.mode == MODE_SURGE;
  assign eval_en = !all_low;
  assign step_en = eval_en && step_mode;
  // Reference restarts once a blocking condition goes away
  assign surge_en = eval_en && surge_mode && !blocked && !(|phase_lost);

  // Step supervision sequence
  assign pick_any = |picked;
  assign hit_any = |(picked & step_hit);
  assign timer_out = timer == 16'h0000;
  assign start_run = state == ST_IDLE && pick_any && !blocked;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (start_run)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!pick_any || blocked)
          next_state = ST_IDLE;
        else if (hit_any)
          next_state = ST_TRIP;
        else if (timer_out)
          next_state = ST_LOCK;
      end
      ST_TRIP:
      begin
        if (!pick_any || blocked)
          next_state = ST_IDLE;
      end
      ST_LOCK:
      begin
        // Only a fresh crossing of the pickup threshold rearms
        if (!pick_any)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      timer <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (start_run)
        timer <= interval;
      else if (state == ST_RUN && ms_tick && !timer_out)
        timer <= timer - 16'h0001;
    end
  end

  // Surge decision: count of phases over the angle against the setting
  assign exceed_cnt = 2'({1'b0, exceed[0]} + {1'b0, exceed[1]} + {1'b0, exceed[2]});
  assign need = ctrl.need == 2'b00 ? 2'b01 : ctrl.need;
  // Decided on the crossing itself, well inside three mains cycles
  assign surge_cond = surge_en && exceed_cnt >= need;

  assign next_alarm = state == ST_RUN || state == ST_TRIP || surge_cond;
  assign next_trip = state == ST_TRIP || surge_cond;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarm <= 1'b0;
      trip <= 1'b0;
      surge_q <= 1'b0;
    end
    else
    begin
      alarm <= next_alarm;
      trip <= next_trip;
      surge_q <= surge_cond;
    end
  end

  // Events: alarm rise, trip rise, lock entry, surge rise
  assign events = {surge_cond && !surge_q,
                   next_state == ST_LOCK && state != ST_LOCK,
                   next_trip && !trip,
                   next_alarm && !alarm};

  // Bus slave: one wait cycle, read data captured on the first edge
  assign waitrequest = (read || write) && !ack;
  assign done = (read || write) && ack;
  assign wr_done = done && write;
  assign rd_clear = done && read && reg_hit(address, `FSP_REG_IRQ_STAT);

  assign rd_mux =
    reg_hit(address, `FSP_REG_CTRL) ? {27'h0, ctrl} :
    reg_hit(address, `FSP_REG_PICKUP) ? {16'h0, pickup} :
    reg_hit(address, `FSP_REG_STEP) ? {16'h0, step} :
    reg_hit(address, `FSP_REG_INTERVAL) ? {16'h0, interval} :
    reg_hit(address, `FSP_REG_UV) ? {16'h0, uv_thr} :
    reg_hit(address, `FSP_REG_SURGE) ? {24'h0, surge_deg} :
    reg_hit(address, `FSP_REG_NOMINAL) ? {16'h0, nominal} :
    reg_hit(address, `FSP_REG_STATE) ? {21'h0, exceed, picked, state, all_low, trip, alarm} :
    reg_hit(address, `FSP_REG_IRQ_STAT) ? {28'h0, irq_stat} :
    reg_hit(address, `FSP_REG_IRQ_MASK) ? {28'h0, irq_mask} :
    32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= (read || write) && !ack;
      if (read && !ack)
        readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= fsp_ctrl_s'(`FSP_RST_CTRL);
      pickup <= `FSP_RST_PICKUP;
      step <= `FSP_RST_STEP;
      interval <= `FSP_RST_INTERVAL;
      uv_thr <= `FSP_RST_UV;
      surge_deg <= `FSP_RST_SURGE;
      nominal <= `FSP_RST_NOMINAL;
      irq_mask <= 4'h0;
    end
    else if (wr_done)
    begin
      if (reg_hit(address, `FSP_REG_CTRL))
        ctrl <= fsp_ctrl_s'(writedata[4:0]);
      if (reg_hit(address, `FSP_REG_PICKUP))
        pickup <= writedata[15:0];
      if (reg_hit(address, `FSP_REG_STEP))
        step <= writedata[15:0];
      if (reg_hit(address, `FSP_REG_INTERVAL))
        interval <= writedata[15:0];
      if (reg_hit(address, `FSP_REG_UV))
        uv_thr <= writedata[15:0];
      // Zero angle would let noise trip, so one degree is the floor
      if (reg_hit(address, `FSP_REG_SURGE))
        surge_deg <= writedata[7:0] == 8'h00 ? 8'h01 : writedata[7:0];
      if (reg_hit(address, `FSP_REG_NOMINAL))
        nominal <= writedata[15:0];
      if (reg_hit(address, `FSP_REG_IRQ_MASK))
        irq_mask <= writedata[3:0];
    end
  end

  // Sticky status: a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_stat <= 4'h0;
    else
      irq_stat <= (irq_stat & ~{4{rd_clear}}) | events;
  end

  assign irq = |(irq_stat & irq_mask);

endmodule // fsp_top

// File: verif/fsp_properties.sv
// Purpose: Port properties of the protection element.
// Assumes: UV threshold stays at its reset value.
// Notes:   Bound to every fsp_top instance.
`include "fsp_params.svh"
module fsp_properties
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input fsp_phase_s meas_a_b,
  input fsp_phase_s meas_b_c,
  input fsp_phase_s meas_c_a,
  input wire logic [2:0] zero_cross,
  input wire logic block_in,
  input wire logic [2:0] phase_lost,
  input wire logic alarm,
  input wire logic trip,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic all_low;
  assign all_low = (meas_a_b.mag < `FSP_RST_UV) && (meas_b_c.mag < `FSP_RST_UV)
    && (meas_c_a.mag < `FSP_RST_UV);
  sequence s_grant;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_held_block;
    block_in [*3];
  endsequence
  property p_wait;
    $rose(read || write) |-> s_grant;
  endproperty
  a_wait: assert property (p_wait) else $error("request not answered after one wait");
  property p_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait raised with no request");
  property p_rd_hold;
    !read |=> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_unmapped;
    read && !waitrequest && address > 6'h24 |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_trip_alarm;
    trip |-> alarm;
  endproperty
  a_trip_alarm: assert property (p_trip_alarm) else $error("trip without alarm");
  property p_block;
    s_held_block |-> !alarm && !trip;
  endproperty
  a_block: assert property (p_block) else $error("output while blocked");
  property p_alarm_free;
    $rose(alarm) |-> !$past(block_in, 1) || !$past(block_in, 2);
  endproperty
  a_alarm_free: assert property (p_alarm_free) else $error("alarm rose while blocked");
  // Low voltage must win over any decision that follows it
  property p_lowv;
    $rose(trip) |-> !$past(all_low, 4);
  endproperty
  a_lowv: assert property (p_lowv) else $error("trip after voltage lockout");
endmodule // fsp_properties
bind fsp_top fsp_properties chk_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .meas_a_b(meas_a_b), .meas_b_c(meas_b_c), .meas_c_a(meas_c_a), .zero_cross(zero_cross),
  .block_in(block_in), .phase_lost(phase_lost), .alarm(alarm), .trip(trip), .irq(irq));

// File: verif/fsp_partner.sv
// Purpose: Model of the three measured line voltages.
// Assumes: One frequency value for all phases.
// Notes:   A lost phase stops crossing; slow adds extra, which may be negative, to the next cycle.
module fsp_partner
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] freq,
  input wire logic [2:0] low,
  input wire logic [2:0] slow,
  input wire logic [2:0] dead,
  input int period,
  input int extra,
  output fsp_phase_s meas_a_b,
  output fsp_phase_s meas_b_c,
  output fsp_phase_s meas_c_a,
  output wire logic [2:0] zero_cross
);
  timeunit 1ns;
  timeprecision 100ps;
  // Low phases sit one step under the lockout level, others right on it
  assign meas_a_b = {freq, 16'h0100 - {15'h0, low[0]}};
  assign meas_b_c = {freq, 16'h0100 - {15'h0, low[1]}};
  assign meas_c_a = {freq, 16'h0100 - {15'h0, low[2]}};
  for (genvar i = 0; i < 3; i++)
  begin : g_ph
    int cnt = 0;
    int len = 2000;
    always @(posedge clk)
    begin
      cnt <= (cnt + 1 >= len) ? 0 : cnt + 1;
      if (cnt + 1 >= len)
        len <= period + (slow[i] ? extra : 0);
    end
    assign zero_cross[i] = !dead[i] && (cnt < len / 2);
  end
endmodule // fsp_partner

// File: verif/fsp_top_bench.sv
// Purpose: Self-checking bench of the protection element.
// Assumes: Cycle lengths are whole microseconds, so counts are exact.
// Notes:   Lock case uses a zero interval, which expires at once, to stay short.
`include "fsp_params.svh"
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("FAIL t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module fsp_top_bench
  import fsp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0;
  logic rst_b = 0;
  logic [5:0] address = 6'h00;
  logic read = 0;
  logic write = 0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, alarm, trip, irq, seen;
  fsp_phase_s meas_a_b, meas_b_c, meas_c_a;
  wire logic [2:0] zero_cross;
  logic block_in = 0;
  logic [2:0] phase_lost = 3'h0;
  logic [15:0] freq = 16'hc350;
  logic [2:0] low = 3'h0;
  logic [2:0] slow = 3'h0;
  int period = 2000;
  int extra = 0;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] rv [9] = '{32'h4, 32'hc350, 32'h320, 32'h64, 32'h100, 32'ha, 32'hc350,
    32'h0, 32'h0};
  logic [31:0] sc [5] = '{32'h7, 32'hf, 32'hb, 32'h7, 32'h7};
  logic [2:0] sm [5] = '{3'h7, 3'h3, 3'h3, 3'h4, 3'h4};
  int se [5] = '{200, 600, -600, 600, 600};
  logic [2:0] sl [5] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h0};
  logic st [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  always #2.5 clk = ~clk;
  fsp_top dut_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .meas_a_b(meas_a_b), .meas_b_c(meas_b_c), .meas_c_a(meas_c_a), .zero_cross(zero_cross),
    .block_in(block_in), .phase_lost(phase_lost), .alarm(alarm), .trip(trip), .irq(irq));
  fsp_partner ph_u (.clk(clk), .freq(freq), .low(low), .slow(slow), .dead(phase_lost),
    .period(period), .extra(extra), .meas_a_b(meas_a_b), .meas_b_c(meas_b_c),
    .meas_c_a(meas_c_a), .zero_cross(zero_cross));
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0)
    begin
      n_errors++;
      final_report();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rck(input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic clr();
    block_in <= 1'b1;
    freq <= 16'hc350;
    cyc(4);
    `CHK({alarm, trip}, 2'b00)
    block_in <= 1'b0;
    bus(0, `FSP_REG_IRQ_STAT, 32'h0);
  endtask
  task automatic step(input logic [31:0] c, input logic [15:0] p, f1, f2);
    bus(1, `FSP_REG_PICKUP, {16'h0, p});
    bus(1, `FSP_REG_CTRL, c);
    freq <= f1;
    cyc(5);
    `CHK({alarm, trip}, 2'b10)
    freq <= f2;
    cyc(5);
    `CHK({alarm, trip, irq}, 3'b111)
    rck(`FSP_REG_IRQ_STAT, 32'h3);
    rck(`FSP_REG_IRQ_STAT, 32'h0);
    clr();
  endtask
  task automatic drop(input logic [31:0] c, input logic [15:0] p, f1, fh, fr);
    bus(1, `FSP_REG_PICKUP, {16'h0, p});
    bus(1, `FSP_REG_CTRL, c);
    freq <= f1;
    cyc(5);
    freq <= fh;
    cyc(5);
    bus(0, `FSP_REG_STATE, 32'h0);
    `CHK(q[7:5], 3'b111)
    freq <= fr;
    cyc(5);
    bus(0, `FSP_REG_STATE, 32'h0);
    `CHK(q[7:5], 3'b000)
    clr();
  endtask
  initial
  begin
    cyc(10);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++)
      rck((i < 7) ? 6'(i * 4) : ((i == 7) ? `FSP_REG_IRQ_MASK : 6'h28), rv[i]);
    bus(1, `FSP_REG_IRQ_MASK, 32'hf);
    bus(1, `FSP_REG_INTERVAL, 32'h1);
    // Pickup 49000/51000 mHz; steps of 900 mHz against 800
    step(32'h1, 16'hbf68, 16'hbf04, 16'hbb80);
    step(32'h2, 16'hc738, 16'hc79c, 16'hcb20);
    // Last frequency held and first released, both bands together
    drop(32'h1, 16'hbf68, 16'hbf04, 16'hbf80, 16'hbf81);
    drop(32'h2, 16'hc738, 16'hc79c, 16'hc71f, 16'hc71e);
    bus(1, `FSP_REG_PICKUP, 32'hbf68);
    bus(1, `FSP_REG_CTRL, 32'h1);
    // A 1 ms interval would cost 200000 cycles
    bus(1, `FSP_REG_INTERVAL, 32'h0);
    freq <= 16'hbf04;
    cyc(5);
    n = 0;
    while (alarm !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 100)
    begin
      n_errors++;
      final_report();
    end
    freq <= 16'hbb80;
    cyc(5);
    bus(0, `FSP_REG_STATE, 32'h0);
    `CHK({q[4:3], trip}, 3'b110)
    rck(`FSP_REG_IRQ_STAT, 32'h5);
    bus(1, `FSP_REG_INTERVAL, 32'h1);
    freq <= 16'hc350;
    cyc(5);
    freq <= 16'hbf04;
    cyc(5);
    `CHK(alarm, 1'b1)
    clr();
    low <= 3'b111;
    freq <= 16'hbf04;
    cyc(8);
    `CHK(alarm, 1'b0)
    bus(0, `FSP_REG_STATE, 32'h0);
    `CHK(q[2], 1'b1)
    low <= 3'b110;
    cyc(5);
    `CHK(alarm, 1'b1)
    clr();
    low <= 3'b000;
    // 80 degrees on a 10 us cycle: 3 us deviation trips, 1 us does not
    bus(1, `FSP_REG_SURGE, 32'h50);
    bus(1, `FSP_REG_IRQ_MASK, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      bus(1, `FSP_REG_CTRL, sc[i]);
      phase_lost <= sl[i];
      cyc(6000);
      `CHK(trip, 1'b0)
      slow <= sm[i];
      extra <= se[i];
      seen = 1'b0;
      for (int k = 0; k < 8000; k++)
      begin
        @(posedge clk);
        if (k == 2100)
          slow <= 3'b000;
        seen = seen | (trip === 1'b1);
      end
      `CHK(seen, st[i])
    end
    `CHK(irq, 1'b0)
    bus(1, `FSP_REG_IRQ_MASK, 32'h8);
    `CHK(irq, 1'b1)
    rck(`FSP_REG_IRQ_STAT, 32'hb);
    `CHK(irq, 1'b0)
    final_report();
  end
endmodule // fsp_top_bench
